// *** core/eeprom_defines.svh ***
// constants for the two-wire serial eeprom slave
// Operation
// - while a nonvolatile write runs, slave address bytes get no acknowledge
// - counter holds last word plus one; reads wrap array, writes wrap page
// - read slave address is acknowledged, then eight bits from counter go out
// - stop after address bytes loads counter, outputs nothing, device goes standby
// - each master acknowledge sends the next byte; no acknowledge ends output
// - read counter walks whole array and wraps from top to zero
// - protect register changes only by one-byte write to top address; here a longer write still takes its first byte
// - bits 0, 5, 6 must be written zero and always read zero
// - read at top address returns protect register, then resets, counter zero
// - bit 7 hardware enable, 4 and 3 guards, 2 unlock, 1 write enable
// - guarded array write is acknowledged, changes nothing, starts no cycle
// - guard pair 00 none, 01 upper quarter, 10 upper half, 11 all
// - protect pin plus enable bit block guard bits, enable bit, guarded bytes
// - latches clear at reset; without write enable data bytes get no acknowledge
// - 00000010 sets write enable, 00000000 clears it, no busy cycle
// - unlock guards nonvolatile bits and clears after every nonvolatile write
// - with unlock set write enable cannot clear; step three clears unlock
// - step three with unlock bit set or ended by start changes nothing
// - protect pin and enable both high abort register programming at stop
// - slave byte is type 1010, three select bits, then read bit
// - array is 128 pages of 32 bytes, low five bits pick byte
// - stop ending a write starts busy cycle; data line stays released
`ifndef EEPROM_DEFINES_SVH
`define EEPROM_DEFINES_SVH

`define DEV_TYPE      4'hA
`define REG_ADDR      16'hFFFF
`define ADDR_ZERO     16'h0000
`define ARRAY_LAST    16'h0FFF
`define ARRAY_BITS    12
`define ARRAY_BYTES   4096
`define PAGE_BITS     5
`define GUARD_QUARTER 12'hC00
`define GUARD_HALF    12'h800
`define BIT_HW_EN     7
`define BIT_GUARD_HI  4
`define BIT_GUARD_LO  3
`define BIT_UNLOCK    2
`define BIT_WEL       1
`define UNUSED_MASK   8'h61
`define DATA_WEL_SET  8'h02
`define DATA_WEL_CLR  8'h00
`define DATA_UNLOCK   8'h06
`define LAST_BIT      4'h8
`define ACK_BIT       4'h9
`define BUSY_DEFAULT  1000

`endif

// *** core/eeprom_pkg.sv ***
// types shared by the eeprom slave files
package eeprom_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SLAVE,
    ST_ADDRH,
    ST_ADDRL,
    ST_WDATA,
    ST_READ
  } phase_e;

  typedef struct packed {
    logic sclRise;
    logic sclFall;
    logic start;
    logic stop;
    logic sda;
  } busEvent_s;

  typedef struct packed {
    logic       hwEn;
    logic [1:0] guard;
    logic       unlock;
    logic       write_enable_latch;
  } protect_s;

endpackage

// *** core/bus_condition_detector.sv ***
// pin synchronisers and start, stop and clock edge detection
`timescale 1ns/1ps
`default_nettype none
module bus_condition_detector
  import eeprom_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       sclPin,
  input  wire logic       sdaPin,
  input  wire logic [3:0] auxPins,
  output busEvent_s       busEvent,
  output logic      [3:0] auxLevel
);

  logic       sclMeta, sclSync, sclPrev;
  logic       sdaMeta, sdaSync, sdaPrev;
  logic [3:0] auxMeta;
  logic       next_sclMeta, next_sclSync, next_sclPrev;
  logic       next_sdaMeta, next_sdaSync, next_sdaPrev;
  logic [3:0] next_auxMeta, next_auxLevel;

  // two flops per pin, a third on clock and data keeps history for edge finding
  always_comb
  begin
    next_sclMeta  = sclPin;
    next_sclSync  = sclMeta;
    next_sclPrev  = sclSync;
    next_sdaMeta  = sdaPin;
    next_sdaSync  = sdaMeta;
    next_sdaPrev  = sdaSync;
    next_auxMeta  = auxPins;
    next_auxLevel = auxMeta;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sclMeta  <= 1'b1;
      sclSync  <= 1'b1;
      sclPrev  <= 1'b1;
      sdaMeta  <= 1'b1;
      sdaSync  <= 1'b1;
      sdaPrev  <= 1'b1;
      auxMeta  <= 4'h0;
      auxLevel <= 4'h0;
    end
    else
    begin
      sclMeta  <= next_sclMeta;
      sclSync  <= next_sclSync;
      sclPrev  <= next_sclPrev;
      sdaMeta  <= next_sdaMeta;
      sdaSync  <= next_sdaSync;
      sdaPrev  <= next_sdaPrev;
      auxMeta  <= next_auxMeta;
      auxLevel <= next_auxLevel;
    end
  end

  // data moves only while the clock is low, so an edge on data with
  // the clock high on both samples is a bus condition
  always_comb
  begin
    busEvent.sclRise = sclSync & ~sclPrev;
    busEvent.sclFall = ~sclSync & sclPrev;
    busEvent.start   = sclSync & sclPrev & sdaPrev & ~sdaSync;
    busEvent.stop    = sclSync & sclPrev & ~sdaPrev & sdaSync;
    busEvent.sda     = sdaSync;
  end

endmodule
`default_nettype wire

// *** core/serial_eeprom_core.sv ***
// two-wire eeprom slave: reads, polling and the protect register
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_defines.svh"
module serial_eeprom_core
  import eeprom_pkg::*;
#(
  parameter int WRITE_BUSY_CYCLES = `BUSY_DEFAULT
)
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       sclPin,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe_n,
  input  wire logic [2:0] chipSelectPins,
  input  wire logic       writeProtectPin
);

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------

  function automatic logic guarded(input logic [`ARRAY_BITS-1:0] a,
                                   input logic [1:0] g);
    case (g)
      2'b01:   guarded = (a >= `GUARD_QUARTER);
      2'b10:   guarded = (a >= `GUARD_HALF);
      2'b11:   guarded = 1'b1;
      default: guarded = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] protectByte(input protect_s p);
    protectByte = 8'h00;
    protectByte[`BIT_HW_EN]    = p.hwEn;
    protectByte[`BIT_GUARD_HI] = p.guard[1];
    protectByte[`BIT_GUARD_LO] = p.guard[0];
    protectByte[`BIT_UNLOCK]   = p.unlock;
    protectByte[`BIT_WEL]      = p.write_enable_latch;
  endfunction

  // --------------------------------------------------------------
  // pins and state
  // --------------------------------------------------------------

  busEvent_s  ev;
  logic [3:0] auxLevel;
  logic [2:0] selSync;
  logic       wpSync;

  bus_condition_detector detector (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .sclPin   (sclPin),
    .sdaPin   (sdaIn),
    .auxPins  ({writeProtectPin, chipSelectPins}),
    .busEvent (ev),
    .auxLevel (auxLevel)
  );

  assign selSync = auxLevel[2:0];
  assign wpSync  = auxLevel[3];

  logic [7:0] mem [0:`ARRAY_BYTES-1];

  phase_e      phase, next_phase, follow, next_follow;
  logic [3:0]  bitCnt, next_bitCnt;
  logic [7:0]  shiftIn, next_shiftIn;
  logic [7:0]  txByte, next_txByte;
  logic [7:0]  addrHi, next_addrHi;
  logic [7:0]  regData, next_regData;
  logic [15:0] addr, next_addr;
  logic [31:0] busyCnt, next_busyCnt;
  protect_s    protect, next_protect;
  logic        drive, next_drive;
  logic        acked, next_acked;
  logic        firstByte, next_firstByte;
  logic        pendReg, next_pendReg;
  logic        pendArray, next_pendArray;
  logic        fromReg, next_fromReg;
  logic        loadTx, memWe, decide, hwLocked;
  logic [7:0]  fetch;
  logic [15:0] word;

  // a byte has been taken in and its ninth clock is about to start
  assign decide = ev.sclFall && bitCnt == `LAST_BIT && !ev.start &&
                  !ev.stop && phase != ST_READ && phase != ST_IDLE;
  // pin and enable bit together lock the nonvolatile bits
  assign hwLocked = wpSync & protect.hwEn;
  assign fetch = (addr == `REG_ADDR) ? protectByte(protect)
                                     : mem[addr[`ARRAY_BITS-1:0]];
  assign word = {addrHi, shiftIn};

  // --------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------

  // bus sequencing, counter, protect latches and busy interval
  always_comb
  begin
    next_phase     = phase;
    next_follow    = follow;
    next_bitCnt    = bitCnt;
    next_shiftIn   = shiftIn;
    next_txByte    = txByte;
    next_addrHi    = addrHi;
    next_regData   = regData;
    next_addr      = addr;
    next_busyCnt   = busyCnt;
    next_protect   = protect;
    next_drive     = drive;
    next_acked     = acked;
    next_firstByte = firstByte;
    next_pendReg   = pendReg;
    next_pendArray = pendArray;
    next_fromReg   = fromReg;
    loadTx         = 1'b0;
    memWe          = 1'b0;
    // busy interval counts down on its own
    if (busyCnt != 32'h0)
      next_busyCnt = busyCnt - 32'h1;
    if (ev.start)
    begin
      // a start drops an unfinished register write
      next_phase   = ST_SLAVE;
      next_bitCnt  = 4'h0;
      next_drive   = 1'b0;
      next_pendReg = 1'b0;
    end
    else if (ev.stop)
    begin
      next_phase     = ST_IDLE;
      next_drive     = 1'b0;
      next_pendReg   = 1'b0;
      next_pendArray = 1'b0;
      // stop after array data starts the busy interval
      // any nonvolatile write drops the unlock latch
      if (pendArray)
      begin
        next_busyCnt        = WRITE_BUSY_CYCLES;
        next_protect.unlock = 1'b0;
      end
      // a byte with unused bits set does nothing
      if (pendReg && (regData & `UNUSED_MASK) == 8'h00)
      begin
        if (protect.unlock)
        begin
          // unlock bit set in step three leaves the register alone
          // only the programming pattern moves on from unlock
          if (regData[`BIT_WEL] && !regData[`BIT_UNLOCK])
          begin
            // locked by pin and enable bit, so abort quietly
            if (!hwLocked)
            begin
              next_protect.hwEn   = regData[`BIT_HW_EN];
              next_protect.guard  = {regData[`BIT_GUARD_HI],
                                     regData[`BIT_GUARD_LO]};
              next_protect.unlock = 1'b0;
              next_busyCnt        = WRITE_BUSY_CYCLES;
            end
          end
        end
        else if (regData == `DATA_WEL_SET)
          next_protect.write_enable_latch = 1'b1;
        else if (regData == `DATA_WEL_CLR)
          next_protect.write_enable_latch = 1'b0;
        else if (regData == `DATA_UNLOCK && protect.write_enable_latch)
          next_protect.unlock = 1'b1;
      end
    end
    else if (phase != ST_IDLE && ev.sclRise)
    begin
      if (bitCnt < `LAST_BIT)
      begin
        next_shiftIn = {shiftIn[6:0], ev.sda};
        next_bitCnt  = bitCnt + 4'h1;
      end
      else if (phase == ST_READ && bitCnt == `LAST_BIT)
      begin
        next_acked  = ~ev.sda;
        next_bitCnt = `ACK_BIT;
      end
    end
    else if (phase == ST_READ && ev.sclFall)
    begin
      if (bitCnt < `LAST_BIT)
        next_drive = ~txByte[3'(4'h7 - bitCnt)];
      else if (bitCnt == `LAST_BIT)
        next_drive = 1'b0;
      // after the register byte the device resets itself
      else if (fromReg)
      begin
        next_phase = ST_IDLE;
        next_drive = 1'b0;
      end
      // acknowledge asks for the next byte, none ends output
      else if (acked)
        loadTx = 1'b1;
      else
      begin
        next_phase = ST_IDLE;
        next_drive = 1'b0;
      end
    end
    else if (decide)
    begin
      next_bitCnt = `ACK_BIT;
      next_drive  = 1'b1;
      next_follow = ST_IDLE;
      case (phase)
        ST_SLAVE:
        begin
          // type and select compare, mismatch goes to standby
          // busy device stays silent for polling
          if (shiftIn[7:4] == `DEV_TYPE && shiftIn[3:1] == selSync &&
              busyCnt == 32'h0)
            next_follow = shiftIn[0] ? ST_READ : ST_ADDRH;
          else
            next_drive = 1'b0;
        end
        ST_ADDRH:
        begin
          next_addrHi = shiftIn;
          next_follow = ST_ADDRL;
        end
        ST_ADDRL:
        begin
          // counter loads at once, so a stop here just sets it
          next_addr      = (word == `REG_ADDR) ? `REG_ADDR
                           : {4'h0, word[`ARRAY_BITS-1:0]};
          next_firstByte = 1'b1;
          next_follow    = ST_WDATA;
        end
        ST_WDATA:
        begin
          next_firstByte = 1'b0;
          if (addr == `REG_ADDR)
          begin
            // only the first data byte is taken
            if (firstByte)
            begin
              next_pendReg = 1'b1;
              next_regData = shiftIn;
              next_follow  = ST_WDATA;
            end
            else
              next_drive = 1'b0;
          end
          // write enable low refuses array data
          else if (!protect.write_enable_latch)
            next_drive = 1'b0;
          else
          begin
            next_follow = ST_WDATA;
            // guarded bytes are acknowledged but left unchanged
            if (!guarded(addr[`ARRAY_BITS-1:0], protect.guard))
            begin
              memWe          = 1'b1;
              next_pendArray = 1'b1;
            end
            // write counter wraps within the page
            // low five bits are the byte in page
            next_addr[`PAGE_BITS-1:0] = addr[`PAGE_BITS-1:0] + 5'h01;
          end
        end
        default:
          next_drive = 1'b0;
      endcase
    end
    else if (phase != ST_IDLE && ev.sclFall && bitCnt == `ACK_BIT)
    begin
      next_drive  = 1'b0;
      next_bitCnt = 4'h0;
      next_phase  = follow;
      // read selection goes straight to data
      if (follow == ST_READ)
        loadTx = 1'b1;
    end
    if (loadTx)
    begin
      next_phase   = ST_READ;
      next_bitCnt  = 4'h0;
      next_txByte  = fetch;
      next_drive   = ~fetch[7];
      next_fromReg = (addr == `REG_ADDR);
      // register read leaves the counter at zero
      // read counter wraps over the whole array
      if (addr == `REG_ADDR)
        next_addr = `ADDR_ZERO;
      else
        next_addr = {4'h0, addr[`ARRAY_BITS-1:0] + 12'h001};
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      phase     <= ST_IDLE;
      follow    <= ST_IDLE;
      bitCnt    <= 4'h0;
      shiftIn   <= 8'h00;
      txByte    <= 8'h00;
      addrHi    <= 8'h00;
      regData   <= 8'h00;
      addr      <= `ADDR_ZERO;
      busyCnt   <= 32'h0;
      protect   <= '0;
      drive     <= 1'b0;
      acked     <= 1'b0;
      firstByte <= 1'b0;
      pendReg   <= 1'b0;
      pendArray <= 1'b0;
      fromReg   <= 1'b0;
    end
    else
    begin
      phase     <= next_phase;
      follow    <= next_follow;
      bitCnt    <= next_bitCnt;
      shiftIn   <= next_shiftIn;
      txByte    <= next_txByte;
      addrHi    <= next_addrHi;
      regData   <= next_regData;
      addr      <= next_addr;
      busyCnt   <= next_busyCnt;
      protect   <= next_protect;
      drive     <= next_drive;
      acked     <= next_acked;
      firstByte <= next_firstByte;
      pendReg   <= next_pendReg;
      pendArray <= next_pendArray;
      fromReg   <= next_fromReg;
    end
  end

  // array store; not reset, contents survive like the real cells
  always_ff @(posedge sys_clk)
  begin
    if (memWe)
      mem[addr[`ARRAY_BITS-1:0]] <= shiftIn;
  end

  // open drain: only ever pulls low
  assign sdaOut  = 1'b0;
  assign sdaOe_n = ~drive;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  busyNoAck_a: assert property (
    decide && phase == ST_SLAVE && busyCnt != 32'h0
    |=> !drive && follow == ST_IDLE)
    else $error("slave byte acknowledged while busy");

  busyRelease_a: assert property (
    busyCnt != 32'h0 |-> sdaOe_n)
    else $error("data line driven during busy interval");

  readWrap_a: assert property (
    loadTx && addr == `ARRAY_LAST |=> addr == `ADDR_ZERO)
    else $error("read counter did not wrap to zero");

  regReadEnd_a: assert property (
    loadTx && addr == `REG_ADDR
    |=> addr == `ADDR_ZERO && fromReg
        && (txByte & `UNUSED_MASK) == 8'h00)
    else $error("register read left wrong counter or bits");

  latchOrder_a: assert property (
    protect.unlock |-> protect.write_enable_latch)
    else $error("unlock set without write enable");

  hwLockHold_a: assert property (
    hwLocked |=> $stable(protect.guard) && $stable(protect.hwEn))
    else $error("locked bits changed under hardware protect");

  unlockClear_a: assert property (
    $rose(busyCnt != 32'h0) |-> !protect.unlock)
    else $error("unlock survived a nonvolatile write");

  noWelNack_a: assert property (
    decide && phase == ST_WDATA && addr != `REG_ADDR && !protect.write_enable_latch
    |-> !memWe ##1 !drive && follow == ST_IDLE)
    else $error("data acknowledged with write enable low");

  guardStore_a: assert property (
    memWe |-> !guarded(addr[`ARRAY_BITS-1:0], protect.guard))
    else $error("guarded byte was written");

  regReadSeen_c: cover property (loadTx && addr == `REG_ADDR);
  seqRead_c: cover property (phase == ST_READ && acked ##1 loadTx);
  // pending flag is gone by the time the counter loads, so look one earlier
  programBusy_c: cover property (ev.stop && pendReg && protect.unlock
                                 ##1 busyCnt != 32'h0);
  pollNack_c: cover property (decide && phase == ST_SLAVE &&
                              busyCnt != 32'h0);

endmodule
`default_nettype wire

// *** sim/two_wire_master_model.sv ***
// behavioural two-wire bus master that faces the eeprom slave
`timescale 1ns/1ps
`default_nettype none
module two_wire_master_model
(
  input  wire logic sys_clk,
  input  wire logic sdaWire,
  output logic      sclOut,
  output logic      sdaLow
);
  // clock idles high between frames, data line left to the pull-up
  initial
  begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
  end

  task automatic waitCyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic startCond;
    sdaLow <= 1'b0;
    waitCyc(10);
    sclOut <= 1'b1;
    waitCyc(10);
    sdaLow <= 1'b1;
    waitCyc(10);
    sclOut <= 1'b0;
    waitCyc(10);
  endtask

  // stop, data rising while clock high
  task automatic stopCond;
    sdaLow <= 1'b1;
    waitCyc(10);
    sclOut <= 1'b1;
    waitCyc(10);
    sdaLow <= 1'b0;
    waitCyc(10);
  endtask

  // one 160 ns bit: data set while clock low, sampled mid high phase
  task automatic bitXfer(input logic b, output logic r);
    sdaLow <= ~b;
    waitCyc(10);
    sclOut <= 1'b1;
    waitCyc(10);
    r = sdaWire;
    waitCyc(10);
    sclOut <= 1'b0;
    waitCyc(10);
  endtask

  task automatic byteOut(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitXfer(d[i], r);
    bitXfer(1'b1, r);
    ack = ~r;
  endtask

  // a refused byte leaves the data line high in the ninth clock
  task automatic byteIn(input logic ackIt, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitXfer(1'b1, d[i]);
    bitXfer(~ackIt, r);
  endtask
endmodule
`default_nettype wire

// *** sim/serial_eeprom_read_and_protect_tb.sv ***
// self-checking bench for the two-wire eeprom slave
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_read_and_protect_tb
  import eeprom_pkg::*;
;
  localparam int BUSY = 1500;
  logic [2:0] chipSel = 3'h5;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic writeProtectPin = 1'b0;
  logic sclOut, sdaLow, sdaOut, sdaOe_n;
  wire  sdaWire;
  int   failures = 0;
  int   checkCount = 0;
  int   cycles = 0;
  logic ack, ack1;
  logic [7:0] d0, d1;

  always #2 sys_clk = ~sys_clk;
  // open drain: either party pulling low wins, else pull-up
  assign sdaWire = (sdaOe_n ? 1'b1 : sdaOut) & ~sdaLow;

  two_wire_master_model m (.sys_clk(sys_clk), .sdaWire(sdaWire),
    .sclOut(sclOut), .sdaLow(sdaLow));
  serial_eeprom_core #(.WRITE_BUSY_CYCLES(BUSY)) dut (.sys_clk(sys_clk),
    .rst_n(rst_n), .sclPin(sclOut), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaOe_n(sdaOe_n), .chipSelectPins(chipSel),
    .writeProtectPin(writeProtectPin));

  task automatic wrap_up;
    if (failures == 0 && checkCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // a hang is cut short well past the expected run length
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      failures++;
      wrap_up();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, exp);
    checkCount++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic slave(input logic rd, output logic a);
    m.startCond();
    m.byteOut({4'hA, chipSel, rd}, a);
  endtask

  task automatic setAddr(input logic [15:0] adr);
    slave(1'b0, ack);
    m.byteOut(adr[15:8], ack);
    m.byteOut(adr[7:0], ack);
  endtask

  task automatic wr(input logic [15:0] adr, input logic [7:0] a, b,
                    input logic two);
    setAddr(adr);
    m.byteOut(a, ack);
    if (two)
      m.byteOut(b, ack1);
    m.stopCond();
  endtask

  task automatic rdCur(input logic more);
    slave(1'b1, ack);
    m.byteIn(more, d0);
    if (more)
      m.byteIn(1'b0, d1);
    m.stopCond();
  endtask

  task automatic rdReg(input logic [7:0] exp);
    setAddr(16'hFFFF);
    rdCur(1'b0);
    check("protect register", d0, exp);
  endtask

  task automatic poll(input logic exp);
    slave(1'b0, ack);
    m.stopCond();
    check("poll ack", {7'h00, ack}, {7'h00, exp});
  endtask

  task automatic waitBusy;
    m.waitCyc(BUSY + 100);
  endtask

  task automatic sLatches;
    rdReg(8'h00);
    wr(16'h0010, 8'h11, 8'h00, 1'b0);
    check("data ack without wel", {7'h00, ack}, 8'h00);
    wr(16'hFFFF, 8'h02, 8'h55, 1'b1);
    check("second register byte ack", {7'h00, ack1}, 8'h00);
    poll(1'b1);
    rdReg(8'h02);
    wr(16'hFFFF, 8'h22, 8'h00, 1'b0);
    rdReg(8'h02);
    wr(16'hFFFF, 8'h00, 8'h00, 1'b0);
    rdReg(8'h00);
    wr(16'hFFFF, 8'h02, 8'h00, 1'b0);
  endtask

  task automatic sArray;
    wr(16'h0000, 8'h5A, 8'h00, 1'b0);
    poll(1'b0);
    waitBusy();
    poll(1'b1);
    wr(16'h0FFF, 8'hC3, 8'h3C, 1'b1);
    check("page wrap byte ack", {7'h00, ack1}, 8'h01);
    waitBusy();
  endtask

  task automatic sRead;
    setAddr(16'h0FFF);
    rdCur(1'b1);
    check("top byte", d0, 8'hC3);
    check("wrapped byte", d1, 8'h5A);
    setAddr(16'h0FE0);
    m.stopCond();
    rdCur(1'b0);
    check("page wrapped write", d0, 8'h3C);
    rdReg(8'h02);
    rdCur(1'b0);
    check("read after register", d0, 8'h5A);
  endtask

  // three step sequence, guard 10 and hardware enable set
  task automatic sGuard;
    wr(16'hFFFF, 8'h06, 8'h00, 1'b0);
    rdReg(8'h06);
    wr(16'hFFFF, 8'h92, 8'h00, 1'b0);
    waitBusy();
    rdReg(8'h92);
    wr(16'h0FFF, 8'h00, 8'h00, 1'b0);
    check("guarded write ack", {7'h00, ack}, 8'h01);
    poll(1'b1);
    setAddr(16'h0FFF);
    rdCur(1'b0);
    check("guarded byte", d0, 8'hC3);
    // just below the upper half stays writable
    wr(16'h07FF, 8'hA5, 8'h00, 1'b0);
    waitBusy();
    setAddr(16'h07FF);
    rdCur(1'b0);
    check("unguarded byte", d0, 8'hA5);
  endtask

  task automatic sHwLock;
    writeProtectPin <= 1'b1;
    wr(16'hFFFF, 8'h06, 8'h00, 1'b0);
    rdReg(8'h96);
    wr(16'hFFFF, 8'h02, 8'h00, 1'b0);
    poll(1'b1);
    rdReg(8'h96);
    wr(16'hFFFF, 8'h00, 8'h00, 1'b0);
    rdReg(8'h96);
    writeProtectPin <= 1'b0;
    wr(16'hFFFF, 8'h16, 8'h00, 1'b0);
    rdReg(8'h96);
    // step three cut short by a start instead of a stop
    setAddr(16'hFFFF);
    m.byteOut(8'h02, ack);
    rdReg(8'h96);
    wr(16'hFFFF, 8'h02, 8'h00, 1'b0);
    waitBusy();
    rdReg(8'h02);
  endtask

  task automatic sSelect;
    m.startCond();
    m.byteOut({4'hA, 3'h4, 1'b1}, ack);
    m.stopCond();
    check("wrong select ack", {7'h00, ack}, 8'h00);
    m.startCond();
    m.byteOut({4'hB, chipSel, 1'b0}, ack);
    m.stopCond();
    check("wrong type ack", {7'h00, ack}, 8'h00);
    // an asymmetric pin pattern catches a reversed select compare
    chipSel <= 3'h4;
    m.waitCyc(4);
    slave(1'b0, ack);
    m.stopCond();
    check("moved select ack", {7'h00, ack}, 8'h01);
    chipSel <= 3'h5;
  endtask

  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    m.waitCyc(10);
    sLatches();
    sArray();
    sRead();
    sGuard();
    sHwLock();
    sSelect();
    wrap_up();
  end
endmodule
`default_nettype wire
